//--- gpio_trigger.v
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_map.vh"

module gpio_trigger (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // pad level, asynchronous to sys_clk
  input wire pin,
  // trigger programming
  input wire [`TRIG_WIDTH-1:0] trig_mode,
  input wire enable,
  // one-cycle clear of a latched edge
  input wire clear,
  // result
  output reg pending
);

  reg sync1;
  reg sync2;
  reg sync3;
  reg level;
  reg level_prev;
  reg next_pending;
  reg [2:0] settle;

  // ================================================================
  // decode helpers
  function is_level_mode;
    input [`TRIG_WIDTH-1:0] m;
    begin
      is_level_mode = (m == `TRIG_HIGH) || (m == `TRIG_LOW);
    end
  endfunction

  // ================================================================
  // pad synchroniser; sync1 feeds only sync2
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
      // accept a change only when the last two stages agree
      if (sync2 == sync3) begin
        level <= sync3;
      end
      level_prev <= level;
    end
  end

  // ================================================================
  // settle count: the chain holds reset zeros for a few cycles, so a
  // pad idling high would otherwise look like a rising edge
  always @(posedge sys_clk) begin
    if (!rstn) begin
      settle <= 3'h0;
    end else if (settle != `TRIG_SETTLE) begin
      settle <= settle + 3'h1;
    end
  end

  // ================================================================
  // trigger evaluation; a new edge beats a clear in the same cycle
  always @* begin
    next_pending = pending;
    if (!enable || (settle != `TRIG_SETTLE)) begin
      next_pending = 1'b0;
    end else if (is_level_mode(trig_mode)) begin
      // level modes follow the pad, no latching
      next_pending = (trig_mode == `TRIG_HIGH) ? level : ~level;
    end else begin
      if (clear) begin
        next_pending = 1'b0;
      end
      case (trig_mode)
        `TRIG_RISE: begin
          if (level & ~level_prev) next_pending = 1'b1;
        end
        `TRIG_FALL: begin
          if (~level & level_prev) next_pending = 1'b1;
        end
        `TRIG_BOTH: begin
          if (level ^ level_prev) next_pending = 1'b1;
        end
        default: begin
          next_pending = 1'b0; // unused codes never fire
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      pending <= `PENDING_RESET;
    end else begin
      pending <= next_pending;
    end
  end

endmodule
`default_nettype wire

//--- irq_route_map.vh
`ifndef IRQ_ROUTE_MAP_VH
`define IRQ_ROUTE_MAP_VH

// ==================================================================
// external interrupt request line numbers covered by this block
`define LINE_FIRST 7
`define LINE_LAST 24
`define LINE_SMARTCARD 7
`define LINE_RESERVED 8
`define LINE_PWR_MGMT 9
`define LINE_SPI_MASTER 10
`define LINE_I2C_MASTER 11
`define LINE_PWR_CLK_RST 12
`define LINE_GPIO_COMMON 13
`define LINE_GPIO_FIRST 14

// ==================================================================
// gpio counts
`define GPIO_COUNT 12
`define GPIO_DEDICATED 11

// ==================================================================
// trigger type encoding, 3 bits
`define TRIG_WIDTH 3
`define TRIG_RISE 3'h0
`define TRIG_FALL 3'h1
`define TRIG_BOTH 3'h2
`define TRIG_HIGH 3'h3
`define TRIG_LOW 3'h4

// ==================================================================
// cycles after reset before a pad edge may count
`define TRIG_SETTLE 3'h5

// ==================================================================
// reset values
`define PENDING_RESET 1'b0
`define LINES_RESET 18'h00000

`endif

//--- irq_source_map.v
// Notes on behaviour
// - line 7 follows the smart card contact interface interrupt.
// - line 9 on temperature, over-current, overload or bus supply events.
// - line 10 on SPI master transmit or receive buffer request.
// - line 11 on I2C master transmit or receive buffer request.
// - line 12 on high temperature from sensor 0 or sensor 1.
// - line 12 also on wake-up, standby exit or input gpio event.
// - line 13 is the shared line for pending GPIO1 through GPIO12.
// - GPIO1..GPIO4 drive lines 14..17, each with programmable trigger type.
// - dedicated per-pin lines continue up to line 24 for GPIO11.
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_map.vh"

module irq_source_map #(
  parameter GPIO_COUNT = `GPIO_COUNT,
  parameter GPIO_DEDICATED = `GPIO_DEDICATED
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // smart card contact interface
  input wire smartcard_irq,
  // power management unit events
  input wire pwr_temp_event,
  input wire pwr_over_current,
  input wire pwr_overload,
  input wire pwr_bus_supply_event,
  // master interface buffers
  input wire spi_tx_req,
  input wire spi_rx_req,
  input wire i2c_tx_req,
  input wire i2c_rx_req,
  // power/clock/reset unit events
  input wire temp0_high,
  input wire temp1_high,
  input wire suspend_wakeup,
  input wire standby_exit,
  // gpio pads, bit 0 is GPIO1
  input wire [GPIO_COUNT-1:0] gpio_pin,
  input wire [GPIO_COUNT-1:0] gpio_is_input,
  input wire [GPIO_COUNT-1:0] gpio_irq_enable,
  input wire [GPIO_COUNT*`TRIG_WIDTH-1:0] gpio_trig_mode,
  input wire [GPIO_COUNT-1:0] gpio_clear,
  // status
  output wire [GPIO_COUNT-1:0] gpio_pending,
  // request lines to the interrupt controller, index = line number
  output reg [`LINE_LAST:`LINE_FIRST] irq_line
);

  reg [`LINE_LAST:`LINE_FIRST] next_irq_line;
  wire unit_gpio_event;
  integer i;

  // ================================================================
  // one trigger unit per gpio
  genvar g;
  generate
    for (g = 0; g < GPIO_COUNT; g = g + 1) begin : gpio_unit
      gpio_trigger u_trig (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin(gpio_pin[g]),
        .trig_mode(gpio_trig_mode[g*`TRIG_WIDTH +: `TRIG_WIDTH]),
        .enable(gpio_irq_enable[g]),
        .clear(gpio_clear[g]),
        .pending(gpio_pending[g])
      );
    end
  endgenerate

  // only pins set as inputs may wake the unit line
  assign unit_gpio_event = |(gpio_pending & gpio_is_input);

  // ================================================================
  // line routing; sources are same-clock logic, taken unsynchronised
  always @* begin
    next_irq_line = `LINES_RESET;
    next_irq_line[`LINE_SMARTCARD] = smartcard_irq;
    next_irq_line[`LINE_RESERVED] = 1'b0;
    next_irq_line[`LINE_PWR_MGMT] = pwr_temp_event | pwr_over_current |
      pwr_overload | pwr_bus_supply_event;
    next_irq_line[`LINE_SPI_MASTER] = spi_tx_req | spi_rx_req;
    next_irq_line[`LINE_I2C_MASTER] = i2c_tx_req | i2c_rx_req;
    next_irq_line[`LINE_PWR_CLK_RST] = temp0_high | temp1_high |
      suspend_wakeup | standby_exit | unit_gpio_event;
    next_irq_line[`LINE_GPIO_COMMON] = |gpio_pending;
    // dedicated lines, GPIO1 on line 14 onward
    for (i = 0; i < GPIO_DEDICATED; i = i + 1) begin
      next_irq_line[`LINE_GPIO_FIRST + i] = gpio_pending[i];
    end
  end

  // ================================================================
  // registered outputs: one cycle of latency buys glitch-free lines
  always @(posedge sys_clk) begin
    if (!rstn) begin
      irq_line <= `LINES_RESET;
    end else begin
      irq_line <= next_irq_line;
    end
  end

endmodule
`default_nettype wire

//--- nvic_model.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt controller stand-in: remembers every line seen high
module nvic_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [24:7] irq_line,
  output var logic [24:7] seen
);
  // sticky, so a one-cycle pulse is never missed
  always @(posedge sys_clk) begin
    if (!rstn) seen <= '0;
    else seen <= seen | irq_line;
  end
endmodule
`default_nettype wire

//--- irq_source_map_checker.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_map_checker #(
  parameter GPIO_COUNT = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // peripheral sources
  input wire logic smartcard_irq,
  input wire logic pwr_temp_event,
  input wire logic pwr_over_current,
  input wire logic pwr_overload,
  input wire logic pwr_bus_supply_event,
  input wire logic spi_tx_req,
  input wire logic spi_rx_req,
  input wire logic i2c_tx_req,
  input wire logic i2c_rx_req,
  input wire logic temp0_high,
  input wire logic temp1_high,
  input wire logic suspend_wakeup,
  input wire logic standby_exit,
  // gpio state
  input wire logic [GPIO_COUNT-1:0] gpio_is_input,
  input wire logic [GPIO_COUNT-1:0] gpio_pending,
  // request lines
  input wire logic [24:7] irq_line
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // $past(rstn) skips the first edge after reset release
  property p_l7; $past(rstn) |-> irq_line[7] == $past(smartcard_irq);
  endproperty
  a_l7: assert property (p_l7) else $error("l7");
  property p_l8; irq_line[8] == 1'b0; endproperty
  a_l8: assert property (p_l8) else $error("l8");
  property p_l9; $past(rstn) |-> irq_line[9] == $past(pwr_temp_event |
    pwr_over_current | pwr_overload | pwr_bus_supply_event); endproperty
  a_l9: assert property (p_l9) else $error("l9");
  property p_l10; $past(rstn) |-> irq_line[10] == $past(spi_tx_req |
    spi_rx_req); endproperty
  a_l10: assert property (p_l10) else $error("l10");
  property p_l11; $past(rstn) |-> irq_line[11] == $past(i2c_tx_req |
    i2c_rx_req); endproperty
  a_l11: assert property (p_l11) else $error("l11");
  property p_l12; $past(rstn) |-> irq_line[12] == $past(temp0_high |
    temp1_high | suspend_wakeup | standby_exit |
    (|(gpio_pending & gpio_is_input))); endproperty
  a_l12: assert property (p_l12) else $error("l12");
  property p_l13; $past(rstn) |-> irq_line[13] == $past(|gpio_pending);
  endproperty
  a_l13: assert property (p_l13) else $error("l13");
  property p_ded; $past(rstn) |-> irq_line[24:14] ==
    $past(gpio_pending[10:0]); endproperty
  a_ded: assert property (p_ded) else $error("ded");
  c_sc: cover property (irq_line[7]);
  c_unit: cover property (irq_line[12] && irq_line[14]);
  c_last: cover property (irq_line[13] && irq_line[24]);
endmodule
bind irq_source_map irq_source_map_checker #(.GPIO_COUNT(GPIO_COUNT))
  i_irq_source_map_checker (.*);
`default_nettype wire

//--- irq_source_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_map_tb;
  logic sys_clk = 0, rstn = 0;
  logic [12:0] src = '0;
  logic [11:0] pin = '0, inp = 12'h001, en = 12'hfff, clr = '0;
  logic [35:0] mode = '0;
  wire [11:0] pend;
  wire [24:7] irq_line, seen;
  int n_errors = 0, total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  irq_source_map i_irq_source_map (.sys_clk(sys_clk), .rstn(rstn),
    .smartcard_irq(src[0]), .pwr_temp_event(src[1]),
    .pwr_over_current(src[2]), .pwr_overload(src[3]),
    .pwr_bus_supply_event(src[4]), .spi_tx_req(src[5]),
    .spi_rx_req(src[6]), .i2c_tx_req(src[7]), .i2c_rx_req(src[8]),
    .temp0_high(src[9]), .temp1_high(src[10]), .suspend_wakeup(src[11]),
    .standby_exit(src[12]), .gpio_pin(pin), .gpio_is_input(inp),
    .gpio_irq_enable(en), .gpio_trig_mode(mode), .gpio_clear(clr),
    .gpio_pending(pend), .irq_line(irq_line));
  nvic_model i_nvic_model (.sys_clk(sys_clk), .rstn(rstn),
    .irq_line(irq_line), .seen(seen));
  task automatic chk(input logic [17:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  // inputs move on the falling edge only
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // each peripheral source alone, one edge of latency
  task automatic t_levels;
    int b;
    for (int i = 0; i < 13; i++) begin
      src = 13'h1 << i;
      b = i == 0 ? 0 : i < 5 ? 2 : i < 7 ? 3 : i < 9 ? 4 : 5;
      tick(1);
      chk(irq_line, 18'h1 << b);
      src = '0;
      tick(1);
      chk(irq_line, '0);
    end
    $display("levels done");
  endtask
  // rising edge per pin; only GPIO1 counts as input for line 12
  task automatic t_gpio;
    for (int k = 0; k < 12; k++) begin
      pin[k] = 1;
      tick(8);
      chk(irq_line, 18'h40 | (k < 11 ? 18'h80 << k : 0) |
        (k == 0 ? 18'h20 : 0));
      clr[k] = 1;
      tick(1);
      clr[k] = 0;
      pin[k] = 0;
      tick(8);
      chk(irq_line, '0);
    end
    $display("gpio done");
  endtask
  // all five trigger kinds on GPIO2, then the unused codes 5..7
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      mode[5:3] = 3'(m);
      pin[1] = 1;
      tick(8);
      chk(pend[1], m == 0 || m == 2 || m == 3);
      clr[1] = 1;
      tick(1);
      clr[1] = 0;
      pin[1] = 0;
      tick(8);
      chk(pend[1], m == 1 || m == 2 || m == 4);
      clr[1] = 1;
      tick(1);
      clr[1] = 0;
      tick(2);
    end
    mode = '0;
    // a disabled pin never raises pending
    en[1] = 0;
    pin[1] = 1;
    tick(8);
    chk(pend[1], 1'b0);
    pin[1] = 0;
    en[1] = 1;
    tick(8);
    chk(pend[1], 1'b0);
    $display("modes done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    tick(3);
    rstn = 1;
    tick(1);
    chk(irq_line, '0);
    t_levels;
    t_gpio;
    t_modes;
    chk(seen, 18'h3fffd);
    print_verdict;
  end
endmodule
`default_nettype wire
